// ===== hw/adc_corr_map.svh
`ifndef ADC_CORR_MAP_SVH
`define ADC_CORR_MAP_SVH

// ==========================================================================
// widths
`define RAW_W        12
`define RES_W        14
`define GAIN_W       15
`define OFFS_W       14
`define PROD_W       27
`define SUM_W        17

// ==========================================================================
// coefficient encoding
`define GAIN_FRAC    12
`define GAIN_UNITY   15'h4000
`define OFFS_ZERO    14'h0000

// ==========================================================================
// result shaping
`define HALF_LSB     17'h0_0002
`define RES_MAX      14'h3fff
`define RES_MIN      14'h0000
`define RES_MAX_WIDE 17'h0_3fff
`define RES_CODE_LSB 2

// ==========================================================================
// reference channels
`define MID_EXPECT   12'h07f0
`define TAP_LO_DEF   12'h0410
`define TAP_HI_DEF   12'h0be0

`endif

// ===== hw/adc_corr_pkg.sv
`include "adc_corr_map.svh"

package adc_corr_pkg;

    // ======================================================================
    // conversion channel selected by a command
    typedef enum logic [1:0] {
        CH_EXTERNAL,
        CH_REF_LOW,
        CH_REF_MID,
        CH_REF_HIGH
    } chan_t;

    // ======================================================================
    // command sequencing
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_RAW,
        ST_CORRECT
    } seq_state_t;

    typedef logic [`RAW_W-1:0]  raw_t;
    typedef logic [`RES_W-1:0]  res_t;
    typedef logic [`GAIN_W-1:0] gain_t;
    typedef logic [`OFFS_W-1:0] offs_t;

endpackage

// ===== hw/mac_unit.sv
`include "adc_corr_map.svh"

module mac_unit (
    input  wire logic                core_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                in_valid_i,
    input  wire adc_corr_pkg::raw_t  raw_i,
    input  wire logic                cal_i,
    input  wire adc_corr_pkg::gain_t gain_coefficient_i,
    input  wire adc_corr_pkg::offs_t offset_coefficient_i,
    output logic                     out_valid_o,
    output adc_corr_pkg::res_t       result_o,
    output logic                     sat_o
);
    import adc_corr_pkg::*;

    // ======================================================================
    // operand selection
    gain_t                   gain_sel;
    offs_t                   offs_sel;
    logic [`PROD_W-1:0]      product;

    assign gain_sel = cal_i ? gain_coefficient_i   : `GAIN_UNITY;  // R1 R8
    assign offs_sel = cal_i ? offset_coefficient_i : `OFFS_ZERO;   // R1 R8
    assign product  = `PROD_W'(raw_i) * `PROD_W'(gain_sel);        // R3 R5

    // ======================================================================
    // stage one: product and offset
    logic [`PROD_W-1:0]      prod_q;
    offs_t                   offs_q;
    logic                    v1_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            prod_q <= '0;
            offs_q <= `OFFS_ZERO;
            v1_q   <= 1'b0;
        end else begin
            prod_q <= product;
            offs_q <= offs_sel;
            v1_q   <= in_valid_i;
        end
    end

    // ======================================================================
    // stage two: accumulate, round, saturate
    logic signed [`SUM_W-1:0] scaled;
    logic signed [`SUM_W-1:0] offs_ext;
    logic signed [`SUM_W-1:0] sum;
    logic                     under;
    logic                     over;
    res_t                     clamped;

    assign scaled   = $signed(`SUM_W'(prod_q >> `GAIN_FRAC));         // R4 R6
    assign offs_ext = `SUM_W'($signed(offs_q));
    assign sum      = scaled + offs_ext + $signed(`HALF_LSB);          // R3 R7
    assign under    = sum[`SUM_W-1];                                   // R12
    assign over     = !under && (sum > $signed(`RES_MAX_WIDE));        // R12
    assign clamped  = under ? `RES_MIN : (over ? `RES_MAX : sum[`RES_W-1:0]); // R12

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            out_valid_o <= 1'b0;
            result_o    <= `RES_MIN;
            sat_o       <= 1'b0;
        end else begin
            out_valid_o <= v1_q;
            result_o    <= clamped;  // R6
            sat_o       <= v1_q && (under || over);
        end
    end

endmodule

// ===== hw/adc_gain_offset_correction.sv
// Summary of operation
// R1 - a conversion whose command asks for calibration goes through gain and offset correction.
// R2 - the controller loads both coefficients before any calibrated conversion is requested.
// R3 - a calibrated result is gain coefficient times raw result plus offset coefficient.
// R4 - offset zero and gain one (0x4000) leave the result uncorrected.
// R5 - raw input is 12 bits, gain coefficient 15 bits, offset coefficient 14 bits.
// R6 - the output has 14-bit resolution, a quarter raw LSB per step.
// R7 - a rounding constant of two is added to every result.
// R8 - without calibration the raw result is still multiplied by four and two added.
// R9 - the converter taps are biased for slope below one and positive offset.
// R10 - internal reference channels sit at one quarter and three quarters of full scale.
// R11 - a calibrated mid-scale reference conversion is expected to give code 2032.
// R12 - results below zero clamp to zero and above the 14-bit maximum clamp to it.
`include "adc_corr_map.svh"

module adc_gain_offset_correction #(
    parameter logic [`RAW_W-1:0] TAP_LO = `TAP_LO_DEF,
    parameter logic [`RAW_W-1:0] TAP_HI = `TAP_HI_DEF
) (
    input  wire logic                core_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                gain_load_i,
    input  wire adc_corr_pkg::gain_t gain_coefficient_i,
    input  wire logic                offset_load_i,
    input  wire adc_corr_pkg::offs_t offset_coefficient_i,
    input  wire logic                cmd_valid_i,
    input  wire logic                cmd_cal_i,
    input  wire adc_corr_pkg::chan_t cmd_chan_i,
    input  wire logic                raw_valid_i,
    input  wire adc_corr_pkg::raw_t  raw_data_i,
    output logic                     cmd_ready_o,
    output logic                     conv_start_o,
    output adc_corr_pkg::chan_t      ref_sel_o,
    output adc_corr_pkg::raw_t       tap_lo_o,
    output adc_corr_pkg::raw_t       tap_hi_o,
    output logic                     coeff_ready_o,
    output logic                     result_valid_o,
    output adc_corr_pkg::res_t       result_o,
    output logic                     result_cal_o,
    output logic                     result_sat_o,
    output logic                     mid_miss_o
);
    import adc_corr_pkg::*;

    // ======================================================================
    // coefficient storage
    gain_t      gain_q;
    offs_t      offs_q;
    logic [1:0] loaded_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            gain_q   <= `GAIN_UNITY;  // R4
            offs_q   <= `OFFS_ZERO;   // R4
            loaded_q <= 2'b00;
        end else begin
            if (gain_load_i) begin
                gain_q <= gain_coefficient_i;  // R5
            end
            if (offset_load_i) begin
                offs_q <= offset_coefficient_i;  // R5
            end
            loaded_q <= loaded_q | {gain_load_i, offset_load_i};  // R2
        end
    end

    // ======================================================================
    // command sequencer
    seq_state_t state_q;
    seq_state_t state_d;
    logic       cal_q;
    chan_t      chan_q;
    logic       cmd_take;
    logic       raw_take;
    logic       mac_valid;
    res_t       mac_result;
    logic       mac_sat;

    assign cmd_take = cmd_valid_i && (state_q == ST_IDLE);
    assign raw_take = raw_valid_i && (state_q == ST_WAIT_RAW);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_valid_i) begin
                    state_d = ST_WAIT_RAW;
                end
            end
            ST_WAIT_RAW: begin
                if (raw_valid_i) begin
                    state_d = ST_CORRECT;
                end
            end
            ST_CORRECT: begin
                if (mac_valid) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_q      <= ST_IDLE;
            cal_q        <= 1'b0;
            chan_q       <= CH_EXTERNAL;
            cmd_ready_o  <= 1'b1;
            conv_start_o <= 1'b0;
            ref_sel_o    <= CH_EXTERNAL;
        end else begin
            state_q      <= state_d;
            cmd_ready_o  <= (state_d == ST_IDLE);
            conv_start_o <= cmd_take;
            if (cmd_take) begin
                cal_q     <= cmd_cal_i;   // R1
                chan_q    <= cmd_chan_i;
                ref_sel_o <= cmd_chan_i;  // R10
            end
        end
    end

    // ======================================================================
    // correction datapath
    mac_unit i_mac_unit (
        .core_clk_i           (core_clk_i),
        .sys_rst_i            (sys_rst_i),
        .in_valid_i           (raw_take),
        .raw_i                (raw_data_i),
        .cal_i                (cal_q),
        .gain_coefficient_i   (gain_q),
        .offset_coefficient_i (offs_q),
        .out_valid_o          (mac_valid),
        .result_o             (mac_result),
        .sat_o                (mac_sat)
    );

    // ======================================================================
    // reference taps and mid-scale check
    logic result_fire;
    logic mid_check;

    assign result_fire = mac_valid && (state_q == ST_CORRECT);
    assign mid_check   = cal_q && (chan_q == CH_REF_MID) &&
                         (mac_result[`RES_W-1:`RES_CODE_LSB] != `MID_EXPECT);  // R11

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tap_lo_o       <= TAP_LO;  // R9 R10
            tap_hi_o       <= TAP_HI;  // R9 R10
            coeff_ready_o  <= 1'b0;
            result_valid_o <= 1'b0;
            result_o       <= `RES_MIN;
            result_cal_o   <= 1'b0;
            result_sat_o   <= 1'b0;
            mid_miss_o     <= 1'b0;
        end else begin
            tap_lo_o       <= TAP_LO;
            tap_hi_o       <= TAP_HI;
            coeff_ready_o  <= &loaded_q;  // R2
            result_valid_o <= result_fire;
            if (result_fire) begin
                result_o     <= mac_result;  // R6 R7 R12
                result_cal_o <= cal_q;
                result_sat_o <= mac_sat;     // R12
                mid_miss_o   <= mid_check;   // R11
            end
        end
    end

endmodule

// ===== dv/adc_corr_checker_assertions.sv
`include "adc_corr_map.svh"

module adc_corr_checker
#(
    parameter logic [`RAW_W-1:0] TAP_LO = `TAP_LO_DEF,
    parameter logic [`RAW_W-1:0] TAP_HI = `TAP_HI_DEF
) (
    input wire logic                core_clk_i,
    input wire logic                sys_rst_i,
    input wire logic                cmd_valid_i,
    input wire logic                raw_valid_i,
    input wire adc_corr_pkg::raw_t  raw_data_i,
    input wire logic                cmd_ready_o,
    input wire logic                conv_start_o,
    input wire adc_corr_pkg::chan_t ref_sel_o,
    input wire adc_corr_pkg::raw_t  tap_lo_o,
    input wire adc_corr_pkg::raw_t  tap_hi_o,
    input wire logic                result_valid_o,
    input wire adc_corr_pkg::res_t  result_o,
    input wire logic                result_cal_o,
    input wire logic                result_sat_o,
    input wire logic                mid_miss_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import adc_corr_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    raw_t raw_seen_q;
    always_ff @(posedge core_clk_i) begin
        if (raw_valid_i && !cmd_ready_o) begin
            raw_seen_q <= raw_data_i;
        end
    end
    // ======================================================================
    // assertions
    AST_TAKE: assert property (cmd_valid_i && cmd_ready_o |=> conv_start_o && !cmd_ready_o)
        else $error("command not started");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    AST_LATENCY: assert property (raw_valid_i && !cmd_ready_o |-> ##[2:4] result_valid_o)
        else $error("result late");
    AST_UNCAL: assert property (result_valid_o && !result_cal_o |->
        result_o == {raw_seen_q, 2'b10})
        else $error("uncalibrated format wrong");
    AST_READY: assert property (result_valid_o |-> cmd_ready_o)
        else $error("not ready at result");
    AST_PULSE: assert property (result_valid_o |=> !result_valid_o)
        else $error("result pulse too long");
    AST_HOLD: assert property (!result_valid_o |-> $stable(result_o))
        else $error("result changed without valid");
    AST_SAT: assert property (result_valid_o && result_sat_o |->
        result_o inside {14'h0000, 14'h3fff})
        else $error("clamp value wrong");
    AST_MID: assert property (result_valid_o |->
        mid_miss_o == (result_cal_o && ref_sel_o == CH_REF_MID &&
                       result_o[13:2] != `MID_EXPECT))
        else $error("mid flag wrong");
    AST_TAPS: assert property (tap_lo_o == TAP_LO && tap_hi_o == TAP_HI)
        else $error("tap bias wrong");
    COV_CAL: cover property (result_valid_o && result_cal_o);
    COV_UNCAL: cover property (result_valid_o && !result_cal_o);
    COV_SAT: cover property (result_valid_o && result_sat_o);
endmodule

bind adc_gain_offset_correction adc_corr_checker #(.TAP_LO(TAP_LO), .TAP_HI(TAP_HI)) i_adc_corr_checker (
    .core_clk_i, .sys_rst_i, .cmd_valid_i, .raw_valid_i, .raw_data_i, .cmd_ready_o,
    .conv_start_o, .ref_sel_o, .tap_lo_o, .tap_hi_o, .result_valid_o, .result_o,
    .result_cal_o, .result_sat_o, .mid_miss_o);

// ===== dv/adc_raw_source.sv
module adc_raw_source (
    input  wire logic               core_clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               start_i,
    input  wire adc_corr_pkg::raw_t code_i,
    input  wire logic [3:0]         wait_i,
    output logic                    raw_valid_o = 1'b0,
    output adc_corr_pkg::raw_t      raw_data_o = 12'h0a5
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       busy_q = 1'b0;
    logic [3:0] cnt_q  = 4'h0;
    // ======================================================================
    // one raw result per start, data line inverted on every cycle that raw_valid_o is not driven high
    always @(posedge core_clk_i) begin
        raw_valid_o <= 1'b0;
        raw_data_o  <= ~raw_data_o;
        if (sys_rst_i) begin
            busy_q <= 1'b0;
        end else if (start_i) begin
            busy_q <= 1'b1;
            cnt_q  <= wait_i;
        end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (busy_q) begin
            busy_q      <= 1'b0;
            raw_valid_o <= 1'b1;
            raw_data_o  <= code_i;
        end
    end
endmodule

// ===== dv/test_adc_gain_offset_correction.sv
`include "adc_corr_map.svh"

module test_adc_gain_offset_correction;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_corr_pkg::*;
    logic core_clk_i = 0, sys_rst_i = 1, gain_load_i = 0, offset_load_i = 0;
    logic cmd_valid_i = 0, cmd_cal_i = 0, raw_valid_i, cmd_ready_o, conv_start_o;
    logic coeff_ready_o, result_valid_o, result_cal_o, result_sat_o, mid_miss_o;
    gain_t gain_coefficient_i = 15'h4000, cur_g = 15'h4000;
    offs_t offset_coefficient_i = 14'h0, cur_o = 14'h0;
    chan_t cmd_chan_i = CH_EXTERNAL, ref_sel_o;
    raw_t  raw_data_i, tap_lo_o, tap_hi_o, code = 12'h0;
    res_t  result_o;
    logic [3:0] wait_cyc = 4'h0;
    int errors = 0, comparisons = 0;
    always #25 core_clk_i = ~core_clk_i;
    adc_gain_offset_correction i_adc_gain_offset_correction (
        .core_clk_i           (core_clk_i),
        .sys_rst_i            (sys_rst_i),
        .gain_load_i          (gain_load_i),
        .gain_coefficient_i   (gain_coefficient_i),
        .offset_load_i        (offset_load_i),
        .offset_coefficient_i (offset_coefficient_i),
        .cmd_valid_i          (cmd_valid_i),
        .cmd_cal_i            (cmd_cal_i),
        .cmd_chan_i           (cmd_chan_i),
        .raw_valid_i          (raw_valid_i),
        .raw_data_i           (raw_data_i),
        .cmd_ready_o          (cmd_ready_o),
        .conv_start_o         (conv_start_o),
        .ref_sel_o            (ref_sel_o),
        .tap_lo_o             (tap_lo_o),
        .tap_hi_o             (tap_hi_o),
        .coeff_ready_o        (coeff_ready_o),
        .result_valid_o       (result_valid_o),
        .result_o             (result_o),
        .result_cal_o         (result_cal_o),
        .result_sat_o         (result_sat_o),
        .mid_miss_o           (mid_miss_o)
    );
    adc_raw_source i_adc_raw_source (.core_clk_i, .sys_rst_i, .start_i(conv_start_o),
        .code_i(code), .wait_i(wait_cyc), .raw_valid_o(raw_valid_i), .raw_data_o(raw_data_i));
    // ======================================================================
    // helpers
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic load(input gain_t g, input offs_t o);
        @(posedge core_clk_i);
        {gain_load_i, offset_load_i, gain_coefficient_i, offset_coefficient_i} <= {2'b11, g, o};
        @(posedge core_clk_i);
        {gain_load_i, offset_load_i} <= 2'b00;
        {cur_g, cur_o} = {g, o};
    endtask
    task automatic convert(input logic c, input chan_t ch, input raw_t r, input logic [3:0] w);
        int v;
        logic [14:0] e;
        v = c ? ((int'(r) * int'(cur_g)) >>> 12) + int'(signed'(cur_o)) + 2 : int'(r) * 4 + 2;
        e = (v < 0) ? 15'h4000 : (v > 16383) ? 15'h7fff : {1'b0, 14'(v)};
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_cal_i   <= c;
        cmd_chan_i  <= ch;
        code        <= r;
        wait_cyc    <= w;
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b0;
        for (int i = 0; i < 20 && result_valid_o !== 1'b1; i++) @(negedge core_clk_i);
        check_val({15'h0, result_valid_o}, 16'h0001);
        check_val({1'b0, result_sat_o, result_o}, {1'b0, e});
        check_val({13'h0, result_cal_o, ref_sel_o}, {13'h0, c, ch});
        check_val({15'h0, cmd_ready_o}, 16'h0001);
        check_val({15'h0, mid_miss_o},
                  {15'h0, c && ch == CH_REF_MID && e[13:2] != `MID_EXPECT});
    endtask
    // ======================================================================
    // scenarios
    task automatic t_reset;
        @(negedge core_clk_i);
        check_val({14'h0, cmd_ready_o, coeff_ready_o}, 16'h0002);
        check_val({4'h0, tap_lo_o}, {4'h0, `TAP_LO_DEF});
        check_val({4'h0, tap_hi_o}, {4'h0, `TAP_HI_DEF});
    endtask
    task automatic t_uncal;
        convert(1'b0, CH_EXTERNAL, 12'h0fff, 4'h0);
        convert(1'b0, CH_REF_LOW, 12'h0000, 4'h3);
    endtask
    task automatic t_unity;
        load(15'h4000, 14'h0);
        for (int i = 0; i < 4 && coeff_ready_o !== 1'b1; i++) @(negedge core_clk_i);
        check_val({15'h0, coeff_ready_o}, 16'h0001);
        convert(1'b1, CH_EXTERNAL, 12'h0123, 4'h1);
    endtask
    task automatic t_gain_offset;
        load(15'h3000, 14'h0010);
        convert(1'b1, CH_EXTERNAL, 12'h0800, 4'h0);
        load(15'h5000, 14'h3ff0);
        convert(1'b1, CH_REF_LOW, 12'h0400, 4'h2);
    endtask
    task automatic t_saturate;
        load(15'h7fff, 14'h0);
        convert(1'b1, CH_EXTERNAL, 12'h0fff, 4'h0);
        load(15'h4000, 14'h2000);
        convert(1'b1, CH_REF_HIGH, 12'h0000, 4'h0);
    endtask
    task automatic t_mid;
        load(15'h4000, 14'h0);
        convert(1'b1, CH_REF_MID, 12'h07f0, 4'h0);
        convert(1'b1, CH_REF_MID, 12'h0800, 4'h4);
        convert(1'b0, CH_REF_MID, 12'h0800, 4'h0);
    endtask
    task automatic conclude;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge core_clk_i);
        errors++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_uncal();
        t_unity();
        t_gain_offset();
        t_saturate();
        t_mid();
        conclude();
    end
endmodule
